/* File: rtl/tmw_timer.sv */
// Eight-bit timer with clear-on-match, fast PWM and phase correct PWM waveform generation.
//
// Notes on behaviour
// - Clear-on-match mode flags compare match at top.
// - Compare below count: run to 0xFF, wrap.
// - Toggle action inverts output on each match, in every mode but phase correct.
// - Pin shows output only when direction output.
// - Toggle frequency clk/(2*N*(1+compare)).
// - Prescale factor 1, 8, 64, 256, 1024.
// - Overflow flag set on MAX to zero.
// - Mode 3 counts single slope bottom to max.
// - Fast PWM: reach max, zero next tick.
// - Fast PWM sets overflow flag at max.
// - Fast PWM actions two/three clear/set at match.
// - Fast PWM period is 256 ticks.
// - Fast PWM extremes: spike, or constant level.
// - Fast PWM toggle: square wave, buffered compare.
// - Mode 1 counts dual slope up, down.
// - Phase correct: eight bits, max one tick.
// - Phase correct sets overflow flag at bottom.
// - Phase correct actions by counting direction.
// - Phase correct period is 510 ticks.
// - Phase correct extremes hold output constant.
// - Phase correct output fixed up at max.
// - Advance only on timer tick enable.
`timescale 1ns/10ps
`default_nettype none
module tmw_timer
    import tmw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic waveform_output,
    output logic waveform_pin_out,
    output logic waveform_pin_oe
);
    // ==================================================================
    // Register file
    logic [2:0] clock_select_raw;
    logic [1:0] output_action_select;
    logic [1:0] waveform_mode_select;
    logic pin_direction_out;
    logic [7:0] counter_value;
    logic [7:0] compare_buffer;
    logic [7:0] compare_value_register;
    logic overflow_flag;
    logic compare_match_flag;
    logic count_down;
    logic wave;
    logic [PRESCALE_WIDTH-1:0] prescale_count;
    logic timer_tick_enable;
    logic match_blocked;

    logic access;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp;
    logic wr_flags;
    logic force_strobe;
    logic addr_ok;

    assign access = psel && penable && pready;
    assign addr_ok = (paddr == ADDR_CONTROL) || (paddr == ADDR_COUNTER) ||
                     (paddr == ADDR_COMPARE) || (paddr == ADDR_FLAGS) || (paddr == ADDR_PIN);
    assign wr_ctrl = access && pwrite && (paddr == ADDR_CONTROL) && pstrb[0];
    assign wr_count = access && pwrite && (paddr == ADDR_COUNTER) && pstrb[0];
    assign wr_cmp = access && pwrite && (paddr == ADDR_COMPARE) && pstrb[0];
    assign wr_flags = access && pwrite && (paddr == ADDR_FLAGS) && pstrb[0];
    // The forced action uses the action field held before this write lands.
    assign force_strobe = access && pwrite && (paddr == ADDR_CONTROL) && pstrb[1] &&
                          pwdata[CTRL_FORCE_BIT] && !waveform_mode_select[0];

    // Slave answers in the access cycle: one wait-free APB transfer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // Read data is registered in the setup cycle so it stands in the access cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= APB_ZERO;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                // Clock select reads back exactly as written, stop codes included.
                ADDR_CONTROL: prdata <= {22'h0, pin_direction_out, 1'b0, waveform_mode_select,
                                         output_action_select, 1'b0, clock_select_raw};
                ADDR_COUNTER: prdata <= {24'h0, counter_value};
                ADDR_COMPARE: prdata <= {24'h0, compare_buffer};
                ADDR_FLAGS: prdata <= {30'h0, compare_match_flag, overflow_flag};
                ADDR_PIN: prdata <= {31'h0, wave};
                default: prdata <= APB_ZERO;
            endcase
        end
    end

    // Clock select keeps the divider code; two upper codes (external) read back but stop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_select_raw <= CTRL_RESET[2:0];
            output_action_select <= CTRL_RESET[5:4];
            waveform_mode_select <= CTRL_RESET[7:6];
        end else if (wr_ctrl) begin
            clock_select_raw <= pwdata[CTRL_CLKSEL_LSB +: 3];
            output_action_select <= pwdata[CTRL_ACTION_LSB +: 2];
            waveform_mode_select <= pwdata[CTRL_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_direction_out <= CTRL_RESET[CTRL_DIR_BIT];
        end else if (access && pwrite && (paddr == ADDR_CONTROL) && pstrb[1]) begin
            pin_direction_out <= pwdata[CTRL_DIR_BIT];
        end
    end

    // ==================================================================
    // Prescaler: tick every 1, 8, 64, 256 or 1024 clocks.
    logic tick_due;
    always_comb begin
        case (clock_select_raw)
            3'h1: tick_due = 1'b1;
            3'h2: tick_due = prescale_count[2:0] == 3'(DIV_8 - 1);
            3'h3: tick_due = prescale_count[5:0] == 6'(DIV_64 - 1);
            3'h4: tick_due = prescale_count[7:0] == 8'(DIV_256 - 1);
            3'h5: tick_due = prescale_count == PRESCALE_WIDTH'(DIV_1024 - 1);
            default: tick_due = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_count <= '0;
        end else if (clock_select_raw == 3'h0 || clock_select_raw[2:1] == 2'b11) begin
            prescale_count <= '0;
        end else begin
            prescale_count <= prescale_count + 1'b1;
        end
    end
    assign timer_tick_enable = tick_due;

    // ==================================================================
    // Counter and compare
    logic is_pwm;
    logic at_max;
    logic at_bottom;
    logic match;
    logic [7:0] next_count;
    logic next_down;
    assign is_pwm = waveform_mode_select[0];
    assign at_max = counter_value == COUNT_MAX;
    assign at_bottom = counter_value == COUNT_BOTTOM;
    assign match = counter_value == compare_value_register && !match_blocked;

    always_comb begin
        next_down = count_down;
        case (waveform_mode_select)
            MODE_PHASE: begin
                if (at_max) begin
                    next_down = 1'b1;
                end else if (at_bottom) begin
                    next_down = 1'b0;
                end
                next_count = next_down ? counter_value - 1'b1 : counter_value + 1'b1;
            end
            MODE_CLEAR_ON_MATCH: begin
                // A compare below the count is missed; the count wraps through 0xFF first.
                next_count = match ? COUNT_BOTTOM : counter_value + 1'b1;
                next_down = 1'b0;
            end
            default: begin
                next_count = counter_value + 1'b1;
                next_down = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value <= COUNT_RESET;
            count_down <= 1'b0;
        end else if (wr_count) begin
            counter_value <= pwdata[7:0];
        end else if (timer_tick_enable) begin
            counter_value <= next_count;
            count_down <= next_down;
        end
    end

    // A counter write blocks the compare match on the following tick.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_blocked <= 1'b0;
        end else if (wr_count) begin
            match_blocked <= 1'b1;
        end else if (timer_tick_enable) begin
            match_blocked <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_buffer <= COMPARE_RESET;
        end else if (wr_cmp) begin
            compare_buffer <= pwdata[7:0];
        end
    end

    // PWM modes load at top (phase correct) or bottom (fast); others at once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_value_register <= COMPARE_RESET;
        end else if (!is_pwm) begin
            compare_value_register <= compare_buffer;
        end else if (timer_tick_enable && at_max) begin
            compare_value_register <= compare_buffer;
        end
    end

    // ==================================================================
    // Flags: set wins over a software clear (write one to clear).
    logic ovf_event;
    assign ovf_event = timer_tick_enable &&
                       ((waveform_mode_select == MODE_PHASE) ? (at_bottom && count_down) : at_max);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag <= 1'b1;
        end else if (wr_flags && pwdata[FLAG_OVF_BIT]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_match_flag <= 1'b0;
        end else if (timer_tick_enable && match) begin
            compare_match_flag <= 1'b1;
        end else if (wr_flags && pwdata[FLAG_CMP_BIT]) begin
            compare_match_flag <= 1'b0;
        end
    end

    // ==================================================================
    // Waveform generator
    logic next_wave;
    logic up_level;
    assign up_level = output_action_select == ACT_SET;
    always_comb begin
        next_wave = wave;
        if (force_strobe) begin
            case (output_action_select)
                ACT_TOGGLE: next_wave = !wave;
                ACT_CLEAR: next_wave = 1'b0;
                ACT_SET: next_wave = 1'b1;
                default: next_wave = wave;
            endcase
        end else if (timer_tick_enable) begin
            case (waveform_mode_select)
                MODE_FAST: begin
                    if (output_action_select == ACT_TOGGLE) begin
                        if (match) next_wave = !wave;
                    end else if (output_action_select[1]) begin
                        if (at_max) begin
                            next_wave = !up_level;
                        end else if (match) begin
                            next_wave = up_level;
                        end
                    end
                end
                MODE_PHASE: begin
                    if (output_action_select[1]) begin
                        if (at_max) begin
                            // At top, level matches an up-count match, or a down-count match when compare is MAX.
                            next_wave = (compare_value_register == COUNT_MAX) ? !up_level
                                        : up_level;
                        end else if (match) begin
                            // Direction after the turn decides: a match at bottom acts as up.
                            next_wave = next_down ? !up_level : up_level;
                        end
                    end
                end
                default: begin
                    if (match) begin
                        case (output_action_select)
                            ACT_TOGGLE: next_wave = !wave;
                            ACT_CLEAR: next_wave = 1'b0;
                            ACT_SET: next_wave = 1'b1;
                            default: next_wave = wave;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave <= 1'b0;
        end else begin
            wave <= next_wave;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waveform_output <= 1'b0;
            waveform_pin_out <= 1'b0;
            waveform_pin_oe <= 1'b0;
        end else begin
            waveform_output <= next_wave;
            waveform_pin_out <= next_wave;
            waveform_pin_oe <= pin_direction_out && (output_action_select != ACT_OFF);
        end
    end

    // ==================================================================
    // Checks
    a_tick_gates_count: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(timer_tick_enable) && !$past(wr_count) |-> $stable(counter_value))
        else $error("counter moved without tick");
    a_fast_wraps_zero: assert property (@(posedge clk) disable iff (!rst_n)
        timer_tick_enable && !wr_count && waveform_mode_select == MODE_FAST && at_max
        |=> counter_value == COUNT_BOTTOM)
        else $error("fast pwm did not wrap");
    a_ovf_flag_max: assert property (@(posedge clk) disable iff (!rst_n)
        timer_tick_enable && waveform_mode_select != MODE_PHASE && at_max
        |=> overflow_flag)
        else $error("overflow flag missing at max");
    a_phase_turns: assert property (@(posedge clk) disable iff (!rst_n)
        timer_tick_enable && !wr_count && waveform_mode_select == MODE_PHASE && at_max
        |=> counter_value == 8'hFE)
        else $error("phase correct did not turn");
    a_cmp_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        timer_tick_enable && match |=> compare_match_flag)
        else $error("compare flag missing");
    a_ctc_clear: assert property (@(posedge clk) disable iff (!rst_n)
        timer_tick_enable && !wr_count && waveform_mode_select == MODE_CLEAR_ON_MATCH && match
        |=> counter_value == COUNT_BOTTOM)
        else $error("clear on match failed");
    a_pin_direction: assert property (@(posedge clk) disable iff (!rst_n)
        !pin_direction_out |=> !waveform_pin_oe)
        else $error("pin driven while input");
    a_pwm_buffer_hold: assert property (@(posedge clk) disable iff (!rst_n)
        is_pwm && !(timer_tick_enable && at_max) && !$past(!is_pwm)
        |=> $stable(compare_value_register))
        else $error("compare loaded off boundary");
endmodule : tmw_timer
`default_nettype wire

/* File: rtl/tmw_pkg.sv */
// Package with register map, field layout and constants of the 8-bit waveform timer.
package tmw_pkg;
    // ==================================================================
    // Register map (byte addresses on APB)
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNTER = 8'h04;
    localparam logic [7:0] ADDR_COMPARE = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_PIN = 8'h10;
    // ==================================================================
    // Control register fields
    localparam int CTRL_CLKSEL_LSB = 0;
    localparam int CTRL_ACTION_LSB = 4;
    localparam int CTRL_MODE_LSB = 6;
    localparam int CTRL_FORCE_BIT = 8;
    localparam int CTRL_DIR_BIT = 9;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMP_BIT = 1;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    // ==================================================================
    // Waveform modes and output actions
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PHASE = 2'h1;
    localparam logic [1:0] MODE_CLEAR_ON_MATCH = 2'h2;
    localparam logic [1:0] MODE_FAST = 2'h3;
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // Prescale dividers 1, 8, 64, 256, 1024.
    localparam int DIV_8 = 8;
    localparam int DIV_64 = 64;
    localparam int DIV_256 = 256;
    localparam int DIV_1024 = 1024;
    localparam int PRESCALE_WIDTH = 10;
    localparam logic [31:0] APB_ZERO = 32'h0000_0000;
endpackage : tmw_pkg

/* File: testbench/testbench.sv */
// Self-checking testbench for the eight-bit waveform timer.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import tmw_pkg::*;
;
    // ==================================================================
    // Signals and counters
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, slv_err;
    logic waveform_output, waveform_pin_out, waveform_pin_oe;
    logic [7:0] paddr, cmp;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    int error_cnt, num_checks, seed, n, hi, lo, div;
    tmw_timer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .waveform_output(waveform_output), .waveform_pin_out(waveform_pin_out),
        .waveform_pin_oe(waveform_pin_oe));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==================================================================
    // Helpers
    task results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // The request is held until the edge at which pready is sampled high.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        if (pready !== 1'b1) begin
            check("pready", 32'h0000_0001, 32'h0000_0000);
            results();
        end
        rd = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] a,
        input logic [2:0] c);
        ctrl = 32'h0000_0000;
        ctrl[2:0] = c;
        ctrl[5:4] = a;
        ctrl[7:6] = m;
        ctrl[CTRL_DIR_BIT] = 1'b1;
    endfunction : ctrl
    function automatic int div_of(input int cs);
        div_of = (cs == 1) ? 1 : (cs == 2) ? DIV_8 : (cs == 3) ? DIV_64 :
            (cs == 4) ? DIV_256 : DIV_1024;
    endfunction : div_of
    // Counts cycles until the waveform level differs from its level on entry.
    task wait_change(input int limit, output int cnt);
        logic start;
        start = waveform_output;
        cnt = 0;
        while (waveform_output === start && cnt < limit) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= limit) begin
            check("waveform change", 32'h0000_0001, 32'h0000_0000);
            results();
        end
    endtask : wait_change
    // Stops the timer in normal mode so compare and counter writes land at once.
    task start(input logic [1:0] m, input logic [1:0] a, input int cs, input logic [7:0] c);
        apb(1'b1, ADDR_CONTROL, 32'h0000_0000);
        apb(1'b1, ADDR_COMPARE, {24'h00_0000, c});
        apb(1'b1, ADDR_COUNTER, 32'h0000_0000);
        apb(1'b1, ADDR_FLAGS, 32'h0000_0003);
        apb(1'b1, ADDR_CONTROL, ctrl(m, a, cs[2:0]));
    endtask : start
    // ==================================================================
    // Main sequence
    initial begin
        seed = 32'h85ea_4f5e;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
        check("control reset", {22'h00_0000, CTRL_RESET}, rd);
        apb(1'b0, ADDR_COMPARE, 32'h0000_0000);
        check("compare reset", {24'h00_0000, COMPARE_RESET}, rd);
        apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
        check("flags reset", 32'h0000_0000, rd);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0, slv_err});
        $display("test registers done");
        apb(1'b1, ADDR_CONTROL, ctrl(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, 3'h0));
        repeat (2) @(negedge clk);
        check("pin enable on", 32'h0000_0001, {31'h0, waveform_pin_oe});
        apb(1'b1, ADDR_CONTROL, 32'h0000_0010);
        repeat (2) @(negedge clk);
        check("pin enable off", 32'h0000_0000, {31'h0, waveform_pin_oe});
        $display("test pin done");
        for (int cs = 1; cs <= 5; cs++) begin
            cmp = (cs == 1) ? 8'h00 : 8'(($random(seed) & 7) + 1);
            div = div_of(cs);
            start(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, cs, cmp);
            apb(1'b0, ADDR_CONTROL, 32'h0000_0000);
            check("control readback", ctrl(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, cs[2:0]), rd);
            wait_change(20000, n);
            wait_change(20000, n);
            check("toggle interval", div * (cmp + 1), n);
            check("pin follows", {31'h0, waveform_output}, {31'h0, waveform_pin_out});
        end
        apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
        check("compare flag", 32'h0000_0001, {31'h0, rd[FLAG_CMP_BIT]});
        $display("test toggle done");
        start(MODE_CLEAR_ON_MATCH, ACT_TOGGLE, 1, 8'h0A);
        apb(1'b1, ADDR_COUNTER, 32'h0000_0032);
        wait_change(600, n);
        check("missed match wraps", 32'h0000_0001, {31'h0, n > 200});
        apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
        check("overflow on wrap", 32'h0000_0001, {31'h0, rd[FLAG_OVF_BIT]});
        $display("test wrap done");
        for (int t = 0; t < 6; t++) begin
            cmp = (t < 2) ? 8'h00 : 8'($unsigned($random(seed)) % 254 + 1);
            start((t < 4) ? MODE_FAST : MODE_PHASE, t[0] ? ACT_SET : ACT_CLEAR, 1, cmp);
            wait_change(600, n);
            if (waveform_output !== 1'b1) begin
                wait_change(600, n);
            end
            wait_change(600, hi);
            wait_change(600, lo);
            if (t < 4) begin
                check("fast period", 256, hi + lo);
                check("fast high", t[0] ? 255 - cmp : cmp + 1, hi);
            end else begin
                check("phase period", 510, hi + lo);
                check("phase high", t[0] ? 510 - 2 * cmp : 2 * cmp, hi);
            end
            apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
            check("pwm overflow", 32'h0000_0001, {31'h0, rd[FLAG_OVF_BIT]});
        end
        $display("test pwm done");
        for (int t = 0; t < 3; t++) begin
            cmp = (t == 1) ? 8'h00 : COUNT_MAX;
            start((t == 0) ? MODE_FAST : MODE_PHASE, ACT_CLEAR, 1, cmp);
            repeat (600) @(negedge clk);
            n = 0;
            repeat (520) begin
                @(negedge clk);
                n += (waveform_output !== (t != 1));
            end
            check("constant level", 0, n);
        end
        $display("test extremes done");
        start(MODE_CLEAR_ON_MATCH, ACT_CLEAR, 0, 8'h00);
        apb(1'b1, ADDR_CONTROL, ctrl(MODE_CLEAR_ON_MATCH, ACT_CLEAR, 3'h0) | 32'h0000_0100);
        apb(1'b0, ADDR_PIN, 32'h0000_0000);
        check("forced clear", 32'h0000_0000, rd);
        apb(1'b1, ADDR_CONTROL, ctrl(MODE_CLEAR_ON_MATCH, ACT_SET, 3'h0));
        apb(1'b1, ADDR_CONTROL, ctrl(MODE_CLEAR_ON_MATCH, ACT_SET, 3'h0) | 32'h0000_0100);
        apb(1'b0, ADDR_PIN, 32'h0000_0000);
        check("forced set", 32'h0000_0001, rd);
        apb(1'b0, ADDR_FLAGS, 32'h0000_0000);
        check("force no flag", 32'h0000_0000, rd);
        $display("test force done");
        results();
    end
endmodule : testbench
`default_nettype wire
